// *** rtl/cvt_map.vh ***
// Register map, field positions, reset values and size of the calibration vector
//==============================================================
// Notes on behaviour
// RULE1 - Enabled vector reads return successive state bytes
// RULE2 - Host captures state with 673 reads
// RULE3 - Enabled vector writes load successive state bytes
// RULE4 - Host restores with 673 writes, same order
// RULE5 - Address hold lets streaming bursts reuse port
// RULE6 - Host accesses vector only while calibration halted
// RULE7 - Host must finish all 673 transfers
// RULE8 - Channel A gain adjust, factory loaded, rewritable
// RULE9 - Channel B gain adjust, factory loaded, rewritable
// RULE10 - Reference adjust four bits, upper four reserved
// RULE11 - Channel A termination adjust, factory loaded, rewritable
// RULE12 - Channel B termination adjust, factory loaded, rewritable
// RULE13 - Vector access needs enable bit, reset zero
// RULE14 - Index restarts on enable, advances per access
`ifndef CVT_MAP_VH
`define CVT_MAP_VH
//==============================================================
// Register offsets
`define CVT_ADDR_W 12
`define CVT_OFS_VEC_EN 12'h070
`define CVT_OFS_VEC_PORT 12'h071
`define CVT_OFS_GAIN_A 12'h07A
`define CVT_OFS_GAIN_B 12'h07B
`define CVT_OFS_REF 12'h07C
`define CVT_OFS_TERM_A 12'h07E
`define CVT_OFS_TERM_B 12'h07F
`define CVT_OFS_STATUS 12'h0F0
`define CVT_OFS_HOLD 12'h0F1
//==============================================================
// Fields and reset values
`define CVT_VEC_EN_BIT 0
`define CVT_HALTED_BIT 0
`define CVT_HOLD_BIT 0
`define CVT_REF_MSB 3
`define CVT_RST_VEC_EN 1'h0
`define CVT_RST_HOLD 1'h0
`define CVT_RST_BYTE 8'h00
//==============================================================
// Vector size
`define CVT_VEC_LEN 673
`define CVT_IDX_W 10
`define CVT_IDX_LAST 10'h2A0
`endif

// *** rtl/cvt_vec_mem.v ***
// Calibration state storage, one byte per vector index
`timescale 1ns/10ps
`default_nettype none
`include "cvt_map.vh"
module cvt_vec_mem
(
  input wire clk,
  input wire we,
  input wire [`CVT_IDX_W-1:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata
);
  reg [7:0] mem [0:`CVT_VEC_LEN-1];

  // Synchronous write and registered read
  always @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // cvt_vec_mem
`default_nettype wire

// *** rtl/cvt_trim_reg.v ***
// One factory-loaded, host-rewritable trim register
`timescale 1ns/10ps
`default_nettype none
module cvt_trim_reg
#(
  parameter W = 8
)
(
  input wire clk,
  input wire nrst,
  input wire load,
  input wire [W-1:0] factory,
  input wire we,
  input wire [W-1:0] wdata,
  output reg [W-1:0] q
);
  // Factory value is taken by a clocked load after reset release
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= {W{1'b0}};
    end
    else if (load)
    begin
      q <= factory;
    end
    else if (we)
    begin
      q <= wdata;
    end
  end
endmodule // cvt_trim_reg
`default_nettype wire

// *** rtl/cvt_regs.v ***
// Calibration vector port and trim register bank
`timescale 1ns/10ps
`default_nettype none
`include "cvt_map.vh"
module cvt_regs
(
  input wire clk,
  input wire nrst,
  input wire [`CVT_ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire calibration_halted_flag,
  input wire [7:0] factory_gain_a,
  input wire [7:0] factory_gain_b,
  input wire [3:0] factory_ref,
  input wire [7:0] factory_term_a,
  input wire [7:0] factory_term_b,
  output wire [7:0] input_a_gain_adjust,
  output wire [7:0] input_b_gain_adjust,
  output wire [3:0] reference_voltage_adjust,
  output wire [7:0] input_a_termination_adjust,
  output wire [7:0] input_b_termination_adjust,
  output wire address_hold
);
  //==============================================================
  // Declarations
  reg halted_s1;
  reg halted;
  reg factory_load;
  reg vec_en;
  reg hold;
  reg [`CVT_IDX_W-1:0] vec_idx;
  reg rd_vec_q;
  reg [7:0] reg_rdata;
  reg [7:0] next_rdata;
  wire [7:0] mem_rdata;
  wire vec_hit;
  wire vec_wr;
  wire vec_acc;

  //==============================================================
  // Halted flag comes from the calibration engine domain
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      halted_s1 <= 1'b0;
      halted <= 1'b0;
    end
    else
    begin
      halted_s1 <= calibration_halted_flag;
      halted <= halted_s1;
    end
  end

  // Set by reset, cleared on the first clock after release, to catch factory values
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      factory_load <= 1'b1;
    end
    else
    begin
      factory_load <= 1'b0;
    end
  end

  //==============================================================
  // Control registers
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      vec_en <= `CVT_RST_VEC_EN;
      hold <= `CVT_RST_HOLD;
    end
    else if (wr)
    begin
      // RULE13 enable bit write
      if (addr == `CVT_OFS_VEC_EN)
      begin
        vec_en <= wdata[`CVT_VEC_EN_BIT];
      end
      // RULE5 address hold control
      if (addr == `CVT_OFS_HOLD)
      begin
        hold <= wdata[`CVT_HOLD_BIT];
      end
    end
  end

  assign address_hold = hold;

  //==============================================================
  // Vector port access; ignored while the enable bit is clear
  assign vec_hit = (addr == `CVT_OFS_VEC_PORT) && vec_en;
  assign vec_wr = wr && vec_hit;
  assign vec_acc = (wr || rd) && vec_hit;

  // RULE14 index restart and advance
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      vec_idx <= {`CVT_IDX_W{1'b0}};
    end
    else if (wr && (addr == `CVT_OFS_VEC_EN) && wdata[`CVT_VEC_EN_BIT] && !vec_en)
    begin
      vec_idx <= {`CVT_IDX_W{1'b0}};
    end
    else if (vec_acc)
    begin
      if (vec_idx == `CVT_IDX_LAST)
      begin
        vec_idx <= {`CVT_IDX_W{1'b0}}; // Wrap after last byte
      end
      else
      begin
        vec_idx <= vec_idx + {{(`CVT_IDX_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // RULE1 RULE3 byte store
  cvt_vec_mem u_mem
  (
    .clk(clk),
    .we(vec_wr),
    .addr(vec_idx),
    .wdata(wdata),
    .rdata(mem_rdata)
  );

  //==============================================================
  // RULE8 RULE9 RULE10 RULE11 RULE12 trim registers
  cvt_trim_reg #(.W(8)) u_gain_a
  (
    .clk(clk),
    .nrst(nrst),
    .load(factory_load),
    .factory(factory_gain_a),
    .we(wr && (addr == `CVT_OFS_GAIN_A)),
    .wdata(wdata),
    .q(input_a_gain_adjust)
  );

  cvt_trim_reg #(.W(8)) u_gain_b
  (
    .clk(clk),
    .nrst(nrst),
    .load(factory_load),
    .factory(factory_gain_b),
    .we(wr && (addr == `CVT_OFS_GAIN_B)),
    .wdata(wdata),
    .q(input_b_gain_adjust)
  );

  cvt_trim_reg #(.W(4)) u_ref
  (
    .clk(clk),
    .nrst(nrst),
    .load(factory_load),
    .factory(factory_ref),
    .we(wr && (addr == `CVT_OFS_REF)),
    .wdata(wdata[`CVT_REF_MSB:0]),
    .q(reference_voltage_adjust)
  );

  cvt_trim_reg #(.W(8)) u_term_a
  (
    .clk(clk),
    .nrst(nrst),
    .load(factory_load),
    .factory(factory_term_a),
    .we(wr && (addr == `CVT_OFS_TERM_A)),
    .wdata(wdata),
    .q(input_a_termination_adjust)
  );

  cvt_trim_reg #(.W(8)) u_term_b
  (
    .clk(clk),
    .nrst(nrst),
    .load(factory_load),
    .factory(factory_term_b),
    .we(wr && (addr == `CVT_OFS_TERM_B)),
    .wdata(wdata),
    .q(input_b_termination_adjust)
  );

  //==============================================================
  // Read decode for plain registers; reserved bits read zero
  always @*
  begin
    next_rdata = `CVT_RST_BYTE;
    case (addr)
      `CVT_OFS_VEC_EN: next_rdata = {7'h00, vec_en};
      `CVT_OFS_GAIN_A: next_rdata = input_a_gain_adjust;
      `CVT_OFS_GAIN_B: next_rdata = input_b_gain_adjust;
      `CVT_OFS_REF: next_rdata = {4'h0, reference_voltage_adjust};
      `CVT_OFS_TERM_A: next_rdata = input_a_termination_adjust;
      `CVT_OFS_TERM_B: next_rdata = input_b_termination_adjust;
      `CVT_OFS_STATUS: next_rdata = {7'h00, halted};
      `CVT_OFS_HOLD: next_rdata = {7'h00, hold};
      default: next_rdata = `CVT_RST_BYTE;
    endcase
  end

  // Read data registered; vector byte comes from the store
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata <= `CVT_RST_BYTE;
      rd_vec_q <= 1'b0;
    end
    else
    begin
      reg_rdata <= rd ? next_rdata : `CVT_RST_BYTE;
      rd_vec_q <= rd && vec_hit;
    end
  end

  // RULE1 vector byte returned
  always @*
  begin
    rdata = rd_vec_q ? mem_rdata : reg_rdata;
  end
endmodule // cvt_regs
`default_nettype wire

// *** test/cvt_host.sv ***
// Host model driving the configuration register port
`timescale 1ns/10ps
`default_nettype none
module cvt_host
(
  input wire logic clk,
  output logic [11:0] addr = 12'h000,
  output logic [7:0] wdata = 8'h00,
  output logic wr = 1'b0,
  output logic rd = 1'b0,
  input wire logic [7:0] rdata
);
  task automatic wr_r(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd_r(input logic [11:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
endmodule // cvt_host
`default_nettype wire

// *** test/cvt_regs_props.sv ***
// Port checker for the calibration vector and trim bank
`timescale 1ns/10ps
`default_nettype none
module cvt_props
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [7:0] factory_gain_a,
  input wire logic [7:0] input_a_gain_adjust,
  input wire logic [3:0] reference_voltage_adjust,
  input wire logic address_hold
);
  logic en;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Shadow of the vector enable bit
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      en <= 1'b0;
    else if (wr && addr == 12'h070)
      en <= wdata[0];
  property p_idle; !$past(rd) |-> rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_off; rd && addr == 12'h071 && !en |=> rdata == 8'h00; endproperty
  a_off: assert property (p_off) else $error("vector read while off");
  property p_ga; wr && addr == 12'h07A |=> input_a_gain_adjust == $past(wdata); endproperty
  a_ga: assert property (p_ga) else $error("gain write");
  property p_gar; rd && addr == 12'h07A |=> rdata == $past(input_a_gain_adjust); endproperty
  a_gar: assert property (p_gar) else $error("gain read");
  property p_fac; $rose(nrst) |=> input_a_gain_adjust == $past(factory_gain_a); endproperty
  a_fac: assert property (p_fac) else $error("factory load");
  property p_ref;
    wr && addr == 12'h07C |=> reference_voltage_adjust == $past(wdata[3:0]);
  endproperty
  a_ref: assert property (p_ref) else $error("ref write");
  property p_rsv; rd && addr == 12'h07C |=> rdata[7:4] == 4'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("ref upper bits");
  property p_hold; wr && addr == 12'h0F1 |=> address_hold == $past(wdata[0]); endproperty
  a_hold: assert property (p_hold) else $error("hold write");
  c_vec: cover property (rd && addr == 12'h071 && en);
  c_ref: cover property (wr && addr == 12'h07C);
  c_rst: cover property ($rose(nrst));
endmodule // cvt_props
bind cvt_regs cvt_props chk_u (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .factory_gain_a,
  .input_a_gain_adjust, .reference_voltage_adjust, .address_hold);
`default_nettype wire

// *** test/cvt_regs_bench.sv ***
// Bench for the calibration vector and trim bank
`timescale 1ns/10ps
`default_nettype none
`include "cvt_map.vh"
module cvt_regs_bench;
  localparam logic [7:0] FAC [5] = '{8'h5A, 8'hA5, 8'h09, 8'h3C, 8'hC3};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic halted = 1'b0;
  logic [11:0] addr, a;
  logic [7:0] wdata, rdata, d, m;
  logic wr, rd, hold;
  logic [7:0] ga, gb, ta, tb, pin;
  logic [3:0] rq;
  int fail_count = 0, total_checks = 0, cyc = 0;
  always #2 clk = ~clk;
  cvt_host host_u (.clk, .addr, .wdata, .wr, .rd, .rdata);
  cvt_regs dut_u (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .calibration_halted_flag(halted),
    .factory_gain_a(FAC[0]), .factory_gain_b(FAC[1]), .factory_ref(FAC[2][3:0]),
    .factory_term_a(FAC[3]), .factory_term_b(FAC[4]), .input_a_gain_adjust(ga),
    .input_b_gain_adjust(gb), .reference_voltage_adjust(rq), .input_a_termination_adjust(ta),
    .input_b_termination_adjust(tb), .address_hold(hold));
  task automatic cmp(input logic [7:0] g, e);
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Cut a hung run short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  // Factory values, then rewrite and read back each trim
  task automatic t_trim;
    for (int i = 0; i < 5; i++)
    begin
      a = 12'(12'h07A + i + (i > 2));
      m = (i == 2) ? 8'h0F : 8'hFF;
      host_u.rd_r(a, d);
      cmp(d, FAC[i] & m);
      host_u.wr_r(a, ~FAC[i]);
      host_u.rd_r(a, d);
      cmp(d, ~FAC[i] & m);
      pin = (i == 0) ? ga : (i == 1) ? gb : (i == 2) ? {4'h0, rq} : (i == 3) ? ta : tb;
      cmp(pin, ~FAC[i] & m);
    end
    $display("t_trim end");
  endtask
  // Vector save and restore over the full length
  task automatic t_vec;
    host_u.rd_r(`CVT_OFS_VEC_PORT, d);
    cmp(d, 8'h00);
    @(posedge clk) halted <= 1'b1;
    repeat (4) @(posedge clk);
    host_u.rd_r(`CVT_OFS_STATUS, d);
    cmp(d, 8'h01);
    host_u.wr_r(`CVT_OFS_HOLD, 8'h01);
    cmp({7'h00, hold}, 8'h01);
    host_u.wr_r(`CVT_OFS_VEC_EN, 8'h01);
    for (int i = 0; i < `CVT_VEC_LEN; i++)
      host_u.wr_r(`CVT_OFS_VEC_PORT, 8'(i * 7 + 3));
    host_u.wr_r(`CVT_OFS_VEC_EN, 8'h00);
    host_u.wr_r(`CVT_OFS_VEC_EN, 8'h01);
    for (int i = 0; i <= `CVT_VEC_LEN; i++)
    begin
      host_u.rd_r(`CVT_OFS_VEC_PORT, d);
      cmp(d, 8'(i % `CVT_VEC_LEN * 7 + 3));
    end
    $display("t_vec end");
  endtask
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_trim();
    t_vec();
    report_and_stop();
  end
endmodule // cvt_regs_bench
`default_nettype wire
